// ===== afx_core_model.sv
// core pipeline stand-in: four accumulators and the control register write-back
// assumes the datapath answers one cycle after issue
`timescale 1ns/1ps
`default_nettype none
module afx_core_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [31:0] i_load_val,
    input wire logic i_ctrl_wr,
    input wire logic [31:0] i_ctrl_val,
    output logic [31:0] o_ctrl,
    output logic [31:0] o_upper [4],
    output logic [31:0] o_bottom [4]
);
    // fixed well-formed accumulators, two of them negative
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            o_upper[k] = 32'h7FFFFFF0 ^ (32'(k) << 30);
            o_bottom[k] = 32'hC3A55A3C ^ 32'(k);
        end
    end
    // control value is written back whole when the datapath asks, unless a load arrives in the same cycle and wins
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ctrl <= 32'h00000000;
        end else if (i_load) begin
            o_ctrl <= i_load_val;
        end else if (i_ctrl_wr) begin
            o_ctrl <= i_ctrl_val;
        end
    end
endmodule // afx_core_model
`default_nettype wire

// ===== afx_datapath.sv
// accumulator field extract datapath, one result per issued instruction
// assumes the pipeline supplies instruction, operands and control register on one clock
//
// Function
// [RULE1] decode decrementing variable field extract: 011111, 111000, sub 01011, bits 15..13 zero
// [RULE2] decode non-decrementing variable field extract with sub-operation 00011
// [RULE3] decode word extracts 00000, 00100, 00110; shift from bits 25..21
// [RULE4] field size is low five bits of source one, extract size+1 bits
// [RULE5] start index is control bits 5..0; bit 6 ignored
// [RULE6] extract accumulator bits start down to start-size, upper then bottom half
// [RULE7] valid only when start-(size+1) is at least -1, else failed
// [RULE8] every field extract writes fail flag bit 14 with outcome
// [RULE9] decrementing variant subtracts size+1 from 7-bit index only when valid
// [RULE10] non-decrementing variant leaves index bits 6..0 unchanged
// [RULE11] valid field result is zero-extended to 64 bits
// [RULE12] accumulator 0..3 selected by index; accumulators never modified
// [RULE13] word extract shifts arithmetically, sign-extends low 32 bits
// [RULE14] rounding variants add 1 at most significant discarded bit
// [RULE15] saturating variant clamps to 0x7FFFFFFF on overflow
// [RULE16] word extracts set sticky bit 23 when bits 64..32 not all-equal
// [RULE17] no data-dependent exception is raised
// [RULE18] software supplies well-formed operands; otherwise results undefined
// [RULE19] shifted word is 65 bits with a guard bit below bit 0
// [RULE20] destination and control flags update together in one cycle
`timescale 1ns/1ps
`default_nettype none
`include "afx_defines.svh"

module afx_datapath
    import afx_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_issue,
    input wire logic [31:0] i_instr,
    input wire logic [63:0] i_source_one_gpr,
    input wire logic [31:0] i_upper_half_reg [4],
    input wire logic [31:0] i_bottom_half_reg [4],
    input wire logic [31:0] i_media_ext_control_reg,
    output logic o_reserved,
    output logic o_wr_en,
    output logic [4:0] o_destination_gpr,
    output logic [63:0] o_wr_data,
    output logic o_ctrl_wr,
    output logic [31:0] o_media_ext_control_reg
);

    ////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic afx_op_type decode_op(input logic [31:0] ins);
        afx_op_type op;
        op = AFX_OP_NONE;
        if (ins[31:26] == `AFX_MAJOR_OP && ins[5:0] == `AFX_FUNC_EXTRACT
                && ins[15:13] == 3'h0) begin
            case (ins[10:6])
                `AFX_SUB_VAR_DEC: op = AFX_OP_VAR_DEC; // [RULE1]
                `AFX_SUB_VAR: op = AFX_OP_VAR; // [RULE2]
                `AFX_SUB_WORD: op = AFX_OP_WORD; // [RULE3]
                `AFX_SUB_WORD_RND: op = AFX_OP_WORD_RND; // [RULE3]
                `AFX_SUB_WORD_SAT: op = AFX_OP_WORD_SAT; // [RULE3]
                default: op = AFX_OP_NONE;
            endcase
        end
        return op;
    endfunction

    function automatic logic ovf33(input logic [32:0] v);
        return (v != `AFX_OVF_POS) && (v != `AFX_OVF_NEG); // [RULE16]
    endfunction

    afx_op_type op;
    logic [1:0] acc_idx;
    logic [63:0] acc;
    logic [4:0] size;
    logic [5:0] start_pos;
    logic [6:0] start_ext;
    logic valid_ext;
    logic [63:0] field_mask;
    logic [63:0] field_val;
    logic [4:0] shift_amt;
    logic [64:0] shifted;
    logic [64:0] rounded;
    logic ovf_plain;
    logic ovf_rnd;
    logic [31:0] word_res;
    logic is_field;
    logic is_word;
    logic [6:0] next_pos;
    logic field_lsb;
    logic field_msb;
    logic [31:0] half_up;

    assign op = decode_op(i_instr);
    assign is_field = (op == AFX_OP_VAR_DEC) || (op == AFX_OP_VAR);
    assign is_word = (op == AFX_OP_WORD) || (op == AFX_OP_WORD_RND)
        || (op == AFX_OP_WORD_SAT);
    assign acc_idx = i_instr[12:11];
    // accumulators are read only here
    assign acc = {i_upper_half_reg[acc_idx], i_bottom_half_reg[acc_idx]}; // [RULE12] [RULE6]
    assign size = i_source_one_gpr[4:0]; // [RULE4]
    assign start_pos = i_media_ext_control_reg[5:0]; // [RULE5]
    assign start_ext = {1'b0, start_pos};
    // start-(size+1) >= -1  <=>  start >= size
    assign valid_ext = start_ext >= {2'h0, size}; // [RULE7]
    assign field_mask = ~(64'hFFFFFFFFFFFFFFFE << size); // [RULE4]
    // shift so bit start-size lands at bit 0
    assign field_val = (acc >> (start_pos - {1'b0, size})) & field_mask; // [RULE6] [RULE11]
    assign shift_amt = i_instr[25:21]; // [RULE3]
    // sign-extend then keep a guard bit below bit 0
    assign shifted = 65'($signed({acc, 1'b0}) >>> shift_amt); // [RULE13] [RULE19]
    assign rounded = shifted + 65'h1; // [RULE14]
    assign ovf_plain = ovf33(shifted[64:32]);
    assign ovf_rnd = ovf33(rounded[64:32]);
    // decremented index, only applied on a valid decrementing extract
    assign next_pos = i_media_ext_control_reg[`AFX_POS_W-1:0] - {2'h0, size} - 7'h01; // [RULE9]

    // reference bits for the checks below, read straight from the accumulator
    assign field_lsb = acc[start_pos - {1'b0, size}];
    assign field_msb = acc[start_pos];
    assign half_up = acc[32:1] + {31'h00000000, acc[0]};

    always_comb begin
        case (op)
            AFX_OP_WORD: word_res = shifted[32:1]; // [RULE13]
            AFX_OP_WORD_RND: word_res = rounded[32:1]; // [RULE14]
            AFX_OP_WORD_SAT: word_res = ovf_rnd ? `AFX_Q31_MAX : rounded[32:1]; // [RULE15]
            default: word_res = shifted[32:1];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // result registers; only reserved-instruction is signalled

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_reserved <= 1'b0;
        end else begin
            o_reserved <= i_issue && (op == AFX_OP_NONE); // [RULE17]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wr_en <= 1'b0;
            o_ctrl_wr <= 1'b0;
            o_destination_gpr <= 5'h00;
            o_wr_data <= 64'h0000000000000000;
            o_media_ext_control_reg <= `AFX_CTRL_RESET;
        end else begin
            o_wr_en <= i_issue && (is_word || (is_field && valid_ext)); // [RULE20]
            o_ctrl_wr <= i_issue && (is_word || is_field); // [RULE20]
            o_destination_gpr <= i_instr[20:16];
            if (is_field) begin
                o_wr_data <= field_val; // [RULE11]
            end else begin
                o_wr_data <= {{32{word_res[31]}}, word_res}; // [RULE13]
            end
            o_media_ext_control_reg <= i_media_ext_control_reg;
            if (is_field) begin
                o_media_ext_control_reg[`AFX_EFI_BIT] <= ~valid_ext; // [RULE8]
                if (op == AFX_OP_VAR_DEC && valid_ext) begin
                    o_media_ext_control_reg[`AFX_POS_W-1:0] <= next_pos; // [RULE9]
                end // else [RULE10]
            end
            if (is_word && (ovf_plain || ovf_rnd)) begin
                o_media_ext_control_reg[`AFX_OUF_BIT] <= 1'b1; // [RULE16]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    efi_fail_a: assert property (i_issue && is_field && !valid_ext |=> // [RULE8]
        o_ctrl_wr && o_media_ext_control_reg[`AFX_EFI_BIT] && !o_wr_en)
        else $error("fail flag not set on failed extract");
    efi_ok_a: assert property (i_issue && is_field && valid_ext |=> // [RULE7]
        !o_media_ext_control_reg[`AFX_EFI_BIT] && o_wr_en)
        else $error("valid extract not written");
    pos_dec_a: assert property (i_issue && op == AFX_OP_VAR_DEC && valid_ext |=> // [RULE9]
        o_media_ext_control_reg[6:0] == $past(next_pos))
        else $error("index not decremented");
    pos_keep_a: assert property (i_issue && op == AFX_OP_VAR |=> // [RULE10]
        o_media_ext_control_reg[6:0] == $past(i_media_ext_control_reg[6:0]))
        else $error("index changed");
    field_zext_a: assert property (i_issue && is_field && valid_ext |=> // [RULE11]
        (o_wr_data >> ($past(i_source_one_gpr[4:0]) + 1)) == 64'h0)
        else $error("field not zero-extended");
    word_sext_a: assert property (i_issue && is_word |=> // [RULE13]
        o_wr_data[63:32] == {32{o_wr_data[31]}})
        else $error("word not sign-extended");
    sat_clamp_a: assert property (i_issue && op == AFX_OP_WORD_SAT && ovf_rnd |=> // [RULE15]
        o_wr_data == 64'h000000007FFFFFFF && o_media_ext_control_reg[`AFX_OUF_BIT])
        else $error("saturation missing");
    ovf_sticky_a: assert property (i_issue && is_word && ovf_plain |=> // [RULE16]
        o_media_ext_control_reg[`AFX_OUF_BIT])
        else $error("overflow flag not set");
    rsvd_only_a: assert property (i_issue && op != AFX_OP_NONE |=> !o_reserved) // [RULE17]
        else $error("exception on valid extract");

    ////////////////////////////////////////////////////////////////////////////
    // decode checks, written from the raw instruction fields

    dec_decode_a: assert property (i_issue // [RULE1]
        && i_instr[31:26] == `AFX_MAJOR_OP && i_instr[5:0] == `AFX_FUNC_EXTRACT
        && i_instr[15:13] == 3'h0 && i_instr[10:6] == `AFX_SUB_VAR_DEC
        |=> o_ctrl_wr && !o_reserved)
        else $error("decrementing extract not decoded");

    var_decode_a: assert property (i_issue // [RULE2]
        && i_instr[31:26] == `AFX_MAJOR_OP && i_instr[5:0] == `AFX_FUNC_EXTRACT
        && i_instr[15:13] == 3'h0 && i_instr[10:6] == `AFX_SUB_VAR
        |=> o_ctrl_wr && !o_reserved)
        else $error("plain field extract not decoded");

    word_decode_a: assert property (i_issue // [RULE3]
        && i_instr[31:26] == `AFX_MAJOR_OP && i_instr[5:0] == `AFX_FUNC_EXTRACT
        && i_instr[15:13] == 3'h0
        && (i_instr[10:6] == `AFX_SUB_WORD || i_instr[10:6] == `AFX_SUB_WORD_RND
            || i_instr[10:6] == `AFX_SUB_WORD_SAT)
        |=> o_wr_en && o_ctrl_wr && !o_reserved)
        else $error("word extract not decoded");

    bad_pad_a: assert property (i_issue && i_instr[15:13] != 3'h0 |=> // [RULE1]
        o_reserved && !o_wr_en && !o_ctrl_wr)
        else $error("nonzero pad bits accepted");

    ////////////////////////////////////////////////////////////////////////////
    // field and word result checks

    field_lsb_a: assert property (i_issue && is_field && valid_ext |=> // [RULE6]
        o_wr_data[0] == $past(field_lsb))
        else $error("field low bit wrong");

    field_msb_a: assert property (i_issue && is_field && valid_ext |=> // [RULE5]
        o_wr_data[$past(size)] == $past(field_msb))
        else $error("field high bit wrong");

    dest_sel_a: assert property (i_issue && op != AFX_OP_NONE |=> // [RULE20]
        o_destination_gpr == $past(i_instr[20:16]))
        else $error("destination register wrong");

    word_noshift_a: assert property (i_issue && op == AFX_OP_WORD // [RULE19]
        && shift_amt == 5'h00 |=> o_wr_data[31:0] == $past(acc[31:0]))
        else $error("unshifted word wrong");

    word_round_a: assert property (i_issue && op == AFX_OP_WORD_RND // [RULE14]
        && shift_amt == 5'h01 |=> o_wr_data[31:0] == $past(half_up))
        else $error("rounded word wrong");

    sticky_keep_a: assert property (i_issue && is_word // [RULE16]
        && i_media_ext_control_reg[`AFX_OUF_BIT] |=> o_media_ext_control_reg[`AFX_OUF_BIT])
        else $error("sticky flag cleared");

    word_efi_a: assert property (i_issue && is_word |=> // [RULE8]
        o_media_ext_control_reg[`AFX_EFI_BIT] == $past(i_media_ext_control_reg[`AFX_EFI_BIT]))
        else $error("fail flag touched by word extract");

    field_fail_c: cover property (i_issue && is_field && !valid_ext);
    dec_ok_c: cover property (i_issue && op == AFX_OP_VAR_DEC && valid_ext);
    sat_c: cover property (i_issue && op == AFX_OP_WORD_SAT && ovf_rnd);
    word_c: cover property (i_issue && op == AFX_OP_WORD && !ovf_plain);
    rnd_c: cover property (i_issue && op == AFX_OP_WORD_RND);

endmodule // afx_datapath
`default_nettype wire

// ===== afx_defines.svh
// constants for the accumulator field extract datapath
// assumes inclusion by afx_pkg, the datapath module and the bench
`ifndef AFX_DEFINES_SVH
`define AFX_DEFINES_SVH
`define AFX_MAJOR_OP 6'h1F
`define AFX_FUNC_EXTRACT 6'h38
`define AFX_SUB_VAR_DEC 5'h0B
`define AFX_SUB_VAR 5'h03
`define AFX_SUB_WORD 5'h00
`define AFX_SUB_WORD_RND 5'h04
`define AFX_SUB_WORD_SAT 5'h06
`define AFX_EFI_BIT 14
`define AFX_OUF_BIT 23
`define AFX_POS_W 7
`define AFX_Q31_MAX 32'h7FFFFFFF
`define AFX_OVF_POS 33'h000000000
`define AFX_OVF_NEG 33'h1FFFFFFFF
`define AFX_CTRL_RESET 32'h00000000
`endif

// ===== afx_pkg.sv
// types for the accumulator field extract datapath
// assumes afx_defines.svh is on the include path
`include "afx_defines.svh"
package afx_pkg;
    typedef enum logic [2:0] {
        AFX_OP_NONE = 3'h0,
        AFX_OP_VAR_DEC = 3'h1,
        AFX_OP_VAR = 3'h2,
        AFX_OP_WORD = 3'h3,
        AFX_OP_WORD_RND = 3'h4,
        AFX_OP_WORD_SAT = 3'h5
    } afx_op_type;
    typedef struct packed {
        logic valid;
        logic [63:0] data;
    } afx_result_type;
endpackage

// ===== tb_top.sv
// self-checking bench for the accumulator field extract datapath
// assumes afx_defines.svh on the include path and the core model beside it
`timescale 1ns/1ps
`default_nettype none
`include "afx_defines.svh"
module tb_top;
    logic i_clk = 1'b0, i_rst = 1'b1, i_issue = 1'b0, load = 1'b0;
    logic [31:0] i_instr = 32'h0, load_val = 32'h0, ctrl;
    logic [63:0] i_src = 64'h0, o_wr_data;
    logic [31:0] upper [4], bottom [4], o_ctrl_val;
    logic o_reserved, o_wr_en, o_ctrl_wr;
    logic [4:0] o_dest;
    int num_errors = 0, checked = 0;
    afx_core_model core (.i_clk(i_clk), .i_rst(i_rst), .i_load(load), .i_load_val(load_val),
        .i_ctrl_wr(o_ctrl_wr), .i_ctrl_val(o_ctrl_val), .o_ctrl(ctrl), .o_upper(upper),
        .o_bottom(bottom));
    afx_datapath uut (.i_clk(i_clk), .i_rst(i_rst), .i_issue(i_issue), .i_instr(i_instr),
        .i_source_one_gpr(i_src), .i_upper_half_reg(upper), .i_bottom_half_reg(bottom),
        .i_media_ext_control_reg(ctrl), .o_reserved(o_reserved), .o_wr_en(o_wr_en),
        .o_destination_gpr(o_dest), .o_wr_data(o_wr_data), .o_ctrl_wr(o_ctrl_wr),
        .o_media_ext_control_reg(o_ctrl_val));
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic void ref_op(input logic [4:0] sub, input logic [4:0] sa,
        input logic [63:0] acc, input logic [4:0] size, input logic [31:0] cin,
        output logic en, output logic [63:0] d, output logic [31:0] c);
        logic [64:0] t, r;
        logic ov_r;
        int lo;
        c = cin;
        en = 1'b1;
        d = 64'h0;
        if (sub == `AFX_SUB_VAR_DEC || sub == `AFX_SUB_VAR) begin
            lo = int'(cin[5:0]) - int'(size);
            en = (lo >= 0);
            c[`AFX_EFI_BIT] = ~en;
            if (en) d = (acc >> lo) & ~(64'hFFFFFFFFFFFFFFFF << (size + 6'h01));
            if (en && sub == `AFX_SUB_VAR_DEC) c[6:0] = cin[6:0] - (size + 7'h01);
        end else begin
            t = $signed({acc, 1'b0}) >>> sa;
            r = t + 65'h1;
            ov_r = r[64:32] != `AFX_OVF_POS && r[64:32] != `AFX_OVF_NEG;
            if (ov_r || (t[64:32] != `AFX_OVF_POS && t[64:32] != `AFX_OVF_NEG))
                c[`AFX_OUF_BIT] = 1'b1;
            if (sub == `AFX_SUB_WORD) r = t;
            if (sub == `AFX_SUB_WORD_SAT && ov_r) r[32:1] = `AFX_Q31_MAX;
            d = {{32{r[32]}}, r[32:1]};
        end
    endfunction
    task automatic run(input logic [4:0] sub, input logic [4:0] sa, input logic [1:0] idx,
        input logic [63:0] src, input logic [2:0] pad);
        logic en;
        logic [63:0] d;
        logic [31:0] c;
        logic rsv;
        ref_op(sub, sa, {upper[idx], bottom[idx]}, src[4:0], ctrl, en, d, c);
        rsv = (pad !== 3'h0) || !(sub inside {`AFX_SUB_VAR_DEC, `AFX_SUB_VAR, `AFX_SUB_WORD,
            `AFX_SUB_WORD_RND, `AFX_SUB_WORD_SAT});
        @(posedge i_clk);
        i_issue <= 1'b1;
        i_instr <= {`AFX_MAJOR_OP, sa, 5'h07, pad, idx, sub, `AFX_FUNC_EXTRACT};
        i_src <= src;
        @(posedge i_clk);
        i_issue <= 1'b0;
        #1;
        if (rsv) begin
            chk("reserved", 64'(o_reserved), 64'h1);
            chk("no writes", 64'({o_wr_en, o_ctrl_wr}), 64'h0);
        end else begin
            chk("reserved", 64'(o_reserved), 64'h0);
            chk("wr_en", 64'({o_wr_en, o_ctrl_wr}), 64'({en, 1'b1}));
            if (en) chk("data", o_wr_data, d);
            if (en) chk("dest", 64'(o_dest), 64'h7);
            chk("ctrl", 64'(o_ctrl_val), 64'(c));
        end
        @(posedge i_clk);
        #1;
    endtask
    task automatic set_ctrl(input logic [31:0] v);
        @(posedge i_clk);
        load <= 1'b1;
        load_val <= v;
        @(posedge i_clk);
        load <= 1'b0;
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    logic [4:0] word_sub [3] = '{`AFX_SUB_WORD, `AFX_SUB_WORD_RND, `AFX_SUB_WORD_SAT};
    logic [6:0] pairs [5] = '{7'h1F, 7'h7F, 7'h40, 7'h21, 7'h64};
    initial begin
        #300000;
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        #1;
        chk("idle", 64'({o_reserved, o_wr_en, o_ctrl_wr}), 64'h0);
        set_ctrl(32'h00000028);
        run(`AFX_SUB_VAR_DEC, 5'h00, 2'h1, 64'hFFFFFFFFFFFFFFE7, 3'h0);
        run(`AFX_SUB_VAR_DEC, 5'h00, 2'h2, 64'h000000000000001F, 3'h0);
        run(`AFX_SUB_VAR_DEC, 5'h00, 2'h0, 64'h0, 3'h0);
        run(`AFX_SUB_VAR, 5'h00, 2'h1, 64'h000000000000001E, 3'h0);
        set_ctrl(32'h00004043);
        run(`AFX_SUB_VAR, 5'h00, 2'h3, 64'h3, 3'h0);
        run(`AFX_SUB_VAR_DEC, 5'h00, 2'h3, 64'h7, 3'h0);
        run(`AFX_SUB_VAR, 5'h00, 2'h0, 64'h7, 3'h0);
        run(`AFX_SUB_VAR, 5'h00, 2'h0, 64'h0, 3'h2);
        run(`AFX_SUB_WORD, 5'h00, 2'h0, 64'h0, 3'h4);
        run(5'h01, 5'h00, 2'h0, 64'h0, 3'h0);
        for (int v = 0; v < 3; v++) begin
            for (int p = 0; p < 5; p++) begin
                run(word_sub[v], pairs[p][4:0], pairs[p][6:5], 64'h0, 3'h0);
            end
        end
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
